/* File: logic/pgrw_datapath.sv */
// Purpose: planar graphics controller datapath with its three indexed control registers
// Assumes: host strobes are one cycle and synchronous to sys_clk; neighbouring registers
//          (set/reset, compare colour, ignore planes, bit mask, extension) arrive as inputs
// Notes: all outputs are registered; answers appear one cycle after the strobe
`include "pgrw_defs.svh"

module pgrw_datapath #(
   parameter int DATA_W = 8,
   parameter int ROT_W = 3
) (
   input wire logic sys_clk, // memory clock
   input wire logic rst_n, // chip reset, active low
   input wire logic io_index_wr, // write pulse to the index port
   input wire logic io_data_wr, // write pulse to the data port
   input wire logic io_data_rd, // read pulse on the data port
   input wire logic [7:0] io_wdata, // io write byte
   output logic [7:0] io_rdata, // io read byte
   output logic io_rvalid, // io read answer pulse
   input wire logic latch_rb_rd, // io read of the latch readback register
   input wire logic mem_rd_req, // host memory read pulse
   input wire logic mem_wr_req, // host memory write pulse
   input wire logic [7:0] cpu_wdata, // host memory write byte
   input wire pgrw_pkg::pgrw_planes_t plane_rdata, // planes read at the host address
   input wire logic [3:0] set_reset_val, // set/reset plane values
   input wire logic [3:0] set_reset_en, // set/reset plane enables
   input wire logic [3:0] compare_colour, // compare colour
   input wire logic [3:0] colour_ignore_n, // 0 makes a plane don't care
   input wire logic [7:0] bit_mask, // bit mask
   input wire logic ext_enable, // extension enable bit
   output logic [7:0] cpu_rdata, // host read byte
   output logic cpu_rvalid, // host read answer pulse
   output pgrw_pkg::pgrw_mem_wr_t mem_wr, // plane write data and bit enables
   output logic mem_we, // plane write pulse
   output pgrw_pkg::pgrw_shift_cfg_t shift_cfg // shift register and addressing setup
);

   // refused at elaboration: plane bytes and field positions are fixed at 8 and 3
   if (DATA_W != 8 || ROT_W != 3)
   begin : g_bad_width
      $error("pgrw_datapath: only an 8-bit path with 3-bit rotate is supported");
   end

   logic [7:0] index_reg;
   logic [7:0] rot_func_reg;
   logic [7:0] rd_plane_reg;
   logic [7:0] gfx_mode_reg;
   pgrw_pkg::pgrw_planes_t latch_reg;
   logic [7:0] rotated;
   logic [2:0] wmode;
   logic [1:0] func;
   logic [1:0] plane_sel;
   logic read_mode;
   logic [7:0] compare_bits;
   pgrw_pkg::pgrw_mem_wr_t wr_next;

   assign wmode = gfx_mode_reg[`PGRW_WMODE_LSB +: 3];
   assign func = rot_func_reg[`PGRW_FUNC_LSB +: 2];
   assign plane_sel = rd_plane_reg[1:0];
   assign read_mode = gfx_mode_reg[`PGRW_RMODE_BIT];

   pgrw_rotator #(
      .W(DATA_W),
      .CW(ROT_W)
   ) u_rot (
      .din(cpu_wdata),
      .count(rot_func_reg[`PGRW_ROT_CNT_LSB +: 3]),
      .dout(rotated)
   );

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         index_reg <= 8'h00;
      end
      else if (io_index_wr)
      begin
         index_reg <= io_wdata;
      end
   end

   // reserved bits are masked on write so they always read back zero
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rot_func_reg <= `PGRW_ROT_FUNC_RESET;
         rd_plane_reg <= `PGRW_RD_PLANE_RESET;
         gfx_mode_reg <= `PGRW_GFX_MODE_RESET;
      end
      else if (io_data_wr)
      begin
         unique case (index_reg)
            `PGRW_IDX_ROT_FUNC: rot_func_reg <= io_wdata & `PGRW_ROT_FUNC_MASK;
            `PGRW_IDX_RD_PLANE: rd_plane_reg <= io_wdata & `PGRW_RD_PLANE_MASK;
            `PGRW_IDX_GFX_MODE:
            begin
               gfx_mode_reg <= io_wdata & `PGRW_GFX_MODE_MASK;
               gfx_mode_reg[`PGRW_WMODE_TOP] <= io_wdata[`PGRW_WMODE_TOP] & ext_enable;
            end
            default:
            begin
            end
         endcase
      end
   end

   // other indices belong to neighbouring registers; this block answers zero there
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         io_rdata <= 8'h00;
         io_rvalid <= 1'b0;
      end
      else
      begin
         io_rvalid <= io_data_rd;
         if (io_data_rd)
         begin
            unique case (index_reg)
               `PGRW_IDX_ROT_FUNC: io_rdata <= rot_func_reg;
               `PGRW_IDX_RD_PLANE: io_rdata <= rd_plane_reg;
               `PGRW_IDX_GFX_MODE: io_rdata <= gfx_mode_reg;
               default: io_rdata <= 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         latch_reg <= '0;
      end
      else if (mem_rd_req)
      begin
         latch_reg <= plane_rdata;
      end
   end

   // per pixel: ignored planes force a match, the rest compare to the colour
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         compare_bits[i] = 1'b1;
         for (int p = 0; p < 4; p++)
         begin
            if (colour_ignore_n[p] && (plane_rdata[p][i] != compare_colour[p]))
            begin
               compare_bits[i] = 1'b0;
            end
         end
      end
   end

   // the readback read answers from the latches, which hold the last memory read
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cpu_rdata <= 8'h00;
         cpu_rvalid <= 1'b0;
      end
      else
      begin
         cpu_rvalid <= mem_rd_req | latch_rb_rd;
         if (latch_rb_rd)
         begin
            cpu_rdata <= latch_reg[plane_sel];
         end
         else if (mem_rd_req)
         begin
            if (read_mode)
            begin
               cpu_rdata <= compare_bits;
            end
            else
            begin
               cpu_rdata <= plane_rdata[plane_sel];
            end
         end
      end
   end

   // extended modes 4/5 and reserved codes write nothing here
   always_comb
   begin
      wr_next.data = '0;
      wr_next.bit_en = 8'h00;
      unique case (wmode)
         `PGRW_WMODE_0:
         begin
            wr_next.bit_en = bit_mask;
            for (int p = 0; p < 4; p++)
            begin
               wr_next.data[p] = set_reset_en[p] ? {8{set_reset_val[p]}} : rotated;
               unique case (func)
                  `PGRW_FUNC_PASS: wr_next.data[p] = wr_next.data[p];
                  `PGRW_FUNC_AND: wr_next.data[p] = wr_next.data[p] & latch_reg[p];
                  `PGRW_FUNC_OR: wr_next.data[p] = wr_next.data[p] | latch_reg[p];
                  `PGRW_FUNC_XOR: wr_next.data[p] = wr_next.data[p] ^ latch_reg[p];
               endcase
            end
         end
         `PGRW_WMODE_1:
         begin
            wr_next.data = latch_reg;
            wr_next.bit_en = 8'hff;
         end
         `PGRW_WMODE_2:
         begin
            wr_next.bit_en = bit_mask;
            for (int p = 0; p < 4; p++)
            begin
               wr_next.data[p] = {8{cpu_wdata[p]}};
            end
         end
         `PGRW_WMODE_3:
         begin
            wr_next.bit_en = bit_mask & rotated;
            for (int p = 0; p < 4; p++)
            begin
               wr_next.data[p] = {8{set_reset_val[p]}};
            end
         end
         default:
         begin
            wr_next.data = '0;
            wr_next.bit_en = 8'h00;
         end
      endcase
   end

   // registers are flops, so a data-port write lands before any later access
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_wr <= '0;
         mem_we <= 1'b0;
      end
      else
      begin
         mem_we <= mem_wr_req;
         if (mem_wr_req)
         begin
            mem_wr <= wr_next;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shift_cfg <= '0;
      end
      else
      begin
         shift_cfg.shift_256 <= gfx_mode_reg[`PGRW_SHIFT_256_BIT];
         shift_cfg.shift_cga <= gfx_mode_reg[`PGRW_SHIFT_CGA_BIT]
            & ~gfx_mode_reg[`PGRW_SHIFT_256_BIT];
         shift_cfg.odd_even <= gfx_mode_reg[`PGRW_ODD_EVEN_BIT];
      end
   end

endmodule : pgrw_datapath

/* File: logic/pgrw_defs.svh */
// Purpose: offsets, field positions and reset values of the planar read/write path
// Assumes: indexed register file reached through an index port and a data port
// Notes: register values are 8 bits wide
`ifndef PGRW_DEFS_SVH
`define PGRW_DEFS_SVH

`define PGRW_IDX_ROT_FUNC 8'h03
`define PGRW_IDX_RD_PLANE 8'h04
`define PGRW_IDX_GFX_MODE 8'h05

`define PGRW_ROT_FUNC_MASK 8'h1f
`define PGRW_RD_PLANE_MASK 8'h03
`define PGRW_GFX_MODE_MASK 8'h7f

`define PGRW_ROT_FUNC_RESET 8'h1f
`define PGRW_RD_PLANE_RESET 8'h03
`define PGRW_GFX_MODE_RESET 8'h73

`define PGRW_ROT_CNT_LSB 0
`define PGRW_FUNC_LSB 3
`define PGRW_WMODE_LSB 0
`define PGRW_WMODE_TOP 2
`define PGRW_RMODE_BIT 3
`define PGRW_ODD_EVEN_BIT 4
`define PGRW_SHIFT_CGA_BIT 5
`define PGRW_SHIFT_256_BIT 6

`define PGRW_FUNC_PASS 2'h0
`define PGRW_FUNC_AND 2'h1
`define PGRW_FUNC_OR 2'h2
`define PGRW_FUNC_XOR 2'h3

`define PGRW_WMODE_0 3'h0
`define PGRW_WMODE_1 3'h1
`define PGRW_WMODE_2 3'h2
`define PGRW_WMODE_3 3'h3

`endif

/* File: logic/pgrw_pkg.sv */
// Purpose: shared types of the planar read/write path
// Assumes: four display planes, one byte per plane per access
// Notes: constants live in pgrw_defs.svh
package pgrw_pkg;

   // plane 3 in the top byte, plane 0 in the bottom byte
   typedef logic [3:0][7:0] pgrw_planes_t;

   typedef struct packed
   {
      pgrw_planes_t data;
      logic [7:0] bit_en;
   } pgrw_mem_wr_t;

   typedef struct packed
   {
      logic shift_256;
      logic shift_cga;
      logic odd_even;
   } pgrw_shift_cfg_t;

endpackage : pgrw_pkg

/* File: logic/pgrw_rotator.sv */
// Purpose: right rotate of a CPU data byte by a small count
// Assumes: count below the data width
// Notes: purely combinational
module pgrw_rotator #(
   parameter int W = 8,
   parameter int CW = 3
) (
   input wire logic [W-1:0] din, // incoming data
   input wire logic [CW-1:0] count, // rotate positions
   output logic [W-1:0] dout // rotated data
);

   // refused at elaboration: the double-width shift only rotates when W is 2**CW
   if (W != (1 << CW))
   begin : g_bad_width
      $error("pgrw_rotator: W must equal 2**CW");
   end

   // lsb wraps into msb
   always_comb
   begin
      dout = W'({din, din} >> count);
   end

endmodule : pgrw_rotator

/* File: test/pgrw_datapath_monitor.sv */
// Purpose: port checks of the planar read/write path
// Assumes: one clock, async active-low reset
// Notes: bound from the bench top
module pgrw_datapath_monitor (
   input wire logic sys_clk, // clock
   input wire logic rst_n, // reset
   input wire logic io_data_rd, // io read
   input wire logic [7:0] io_rdata, // io byte
   input wire logic io_rvalid, // io answer
   input wire logic latch_rb_rd, // readback read
   input wire logic mem_rd_req, // memory read
   input wire logic mem_wr_req, // memory write
   input wire logic [7:0] cpu_rdata, // host byte
   input wire logic cpu_rvalid, // host answer
   input wire pgrw_pkg::pgrw_mem_wr_t mem_wr, // plane write
   input wire logic mem_we, // write pulse
   input wire pgrw_pkg::pgrw_shift_cfg_t shift_cfg // shift setup
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd;
      mem_rd_req || latch_rb_rd;
   endsequence
   sequence s_idle;
      !mem_rd_req && !latch_rb_rd;
   endsequence
   AST_IO_ANS: assert property (io_data_rd |=> io_rvalid) else $error("io answer missing");
   AST_IO_ONLY: assert property (!io_data_rd |=> !io_rvalid) else $error("stray io answer");
   AST_CPU_ANS: assert property (s_rd |=> cpu_rvalid) else $error("read answer missing");
   AST_CPU_ONLY: assert property (s_idle |=> !cpu_rvalid) else $error("stray read");
   AST_WE: assert property (mem_wr_req |=> mem_we) else $error("write missing");
   AST_WE_ONLY: assert property (!mem_wr_req |=> !mem_we) else $error("stray write");
   AST_WR_HOLD: assert property (!mem_we |-> $stable(mem_wr)) else $error("write data moved");
   AST_RD_HOLD: assert property (!cpu_rvalid |-> $stable(cpu_rdata)) else $error("read moved");
   AST_SHIFT: assert property (shift_cfg.shift_256 |-> !shift_cfg.shift_cga) else $error("cga set");
endmodule : pgrw_datapath_monitor

/* File: test/pgrw_host_model.sv */
// Purpose: host side issuing io and memory strobes
// Assumes: one strobe per call, held for one clock
// Notes: released lines carry inverted data so stale values never match
module pgrw_host_model (
   input wire logic sys_clk, // clock
   output logic io_index_wr, // index write
   output logic io_data_wr, // data write
   output logic io_data_rd, // data read
   output logic latch_rb_rd, // readback read
   output logic mem_rd_req, // memory read
   output logic mem_wr_req, // memory write
   output logic [7:0] io_wdata, // io byte
   output logic [7:0] cpu_wdata, // memory byte
   output pgrw_pkg::pgrw_planes_t plane_rdata // plane bytes
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {io_index_wr, io_data_wr, io_data_rd, latch_rb_rd, mem_rd_req, mem_wr_req} = 6'h00;
      {io_wdata, cpu_wdata, plane_rdata} = '0;
   end
   task automatic xfer(input logic [5:0] s, input logic [7:0] d, input pgrw_pkg::pgrw_planes_t p);
      @(posedge sys_clk);
      {io_index_wr, io_data_wr, io_data_rd, latch_rb_rd, mem_rd_req, mem_wr_req} <= s;
      {io_wdata, cpu_wdata, plane_rdata} <= {d, d, p};
      @(posedge sys_clk);
      {io_index_wr, io_data_wr, io_data_rd, latch_rb_rd, mem_rd_req, mem_wr_req} <= 6'h00;
      {io_wdata, cpu_wdata, plane_rdata} <= ~{d, d, p};
   endtask : xfer
endmodule : pgrw_host_model

/* File: test/pgrw_datapath_tb.sv */
// Purpose: self-checking bench of the planar read/write path
// Assumes: answers one clock after each strobe
// Notes: random register settings cover every write mode and function
module pgrw_datapath_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst_n, io_index_wr, io_data_wr, io_data_rd, io_rvalid, latch_rb_rd;
   logic mem_rd_req, mem_wr_req, cpu_rvalid, mem_we, ext_enable, chain;
   logic [7:0] io_wdata, io_rdata, cpu_wdata, cpu_rdata, bit_mask, d;
   logic [3:0] set_reset_val, set_reset_en, compare_colour, colour_ignore_n;
   pgrw_pkg::pgrw_planes_t plane_rdata, pl, lat;
   pgrw_pkg::pgrw_mem_wr_t mem_wr;
   pgrw_pkg::pgrw_shift_cfg_t shift_cfg;
   int error_cnt, num_checks, rf, rp, gm;
   pgrw_datapath pgrw_datapath_i (.sys_clk, .rst_n, .io_index_wr, .io_data_wr, .io_data_rd,
      .io_wdata, .io_rdata, .io_rvalid, .latch_rb_rd, .mem_rd_req, .mem_wr_req, .cpu_wdata,
      .plane_rdata, .set_reset_val, .set_reset_en, .compare_colour, .colour_ignore_n,
      .bit_mask, .ext_enable, .cpu_rdata, .cpu_rvalid, .mem_wr, .mem_we, .shift_cfg);
   pgrw_host_model pgrw_host_model_i (.sys_clk, .io_index_wr, .io_data_wr, .io_data_rd,
      .latch_rb_rd, .mem_rd_req, .mem_wr_req, .io_wdata, .cpu_wdata, .plane_rdata);
   always #4 sys_clk = ~sys_clk;
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   task automatic chk(input logic [40:0] got, input logic [40:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic reg_wr(input logic [7:0] idx, input logic [7:0] v);
      pgrw_host_model_i.xfer(6'h20, idx, '0);
      pgrw_host_model_i.xfer(6'h10, v, '0);
   endtask : reg_wr
   task automatic reg_chk(input logic [7:0] idx, input logic [7:0] e);
      pgrw_host_model_i.xfer(6'h20, idx, '0);
      pgrw_host_model_i.xfer(6'h08, 8'h00, '0);
      @(negedge sys_clk);
      chk({io_rvalid, io_rdata}, {1'b1, e});
   endtask : reg_chk
   function automatic logic [7:0] ror(logic [7:0] v, int c);
      return (v >> c) | (v << (8 - c));
   endfunction : ror
   function automatic logic [39:0] exp_wr(logic [7:0] v);
      logic [39:0] e;
      logic [7:0] s;
      int f;
      e = '0;
      f = (rf >> 3) & 3;
      for (int p = 0; p < 4; p++)
      begin
         s = set_reset_en[p] ? {8{set_reset_val[p]}} : ror(v, rf & 7);
         case (gm & 7)
            0: e[8+8*p +: 8] = f == 0 ? s : f == 1 ? s & lat[p] : f == 2 ? s | lat[p] : s ^ lat[p];
            1: e[8+8*p +: 8] = lat[p];
            2: e[8+8*p +: 8] = {8{v[p]}};
            3: e[8+8*p +: 8] = {8{set_reset_val[p]}};
            default: ;
         endcase
      end
      case (gm & 7)
         0, 2: e[7:0] = bit_mask;
         1: e[7:0] = 8'hff;
         3: e[7:0] = bit_mask & ror(v, rf & 7);
         default: ;
      endcase
      return e;
   endfunction : exp_wr
   function automatic logic [7:0] exp_rd(pgrw_pkg::pgrw_planes_t q);
      logic [7:0] r;
      if (!gm[3])
         return q[rp];
      for (int i = 0; i < 8; i++)
      begin
         r[i] = 1'b1;
         for (int p = 0; p < 4; p++)
            if (colour_ignore_n[p] && q[p][i] !== compare_colour[p])
               r[i] = 1'b0;
      end
      return r;
   endfunction : exp_rd
   initial
   begin
      #200000;
      error_cnt++;
      test_done;
   end
   initial
   begin
      {rst_n, sys_clk} = 2'b00;
      {set_reset_val, set_reset_en, compare_colour, colour_ignore_n, bit_mask, ext_enable} = '0;
      error_cnt = 0;
      num_checks = 0;
      void'($urandom(32'h12f6));
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      reg_chk(8'h03, 8'h1f);
      reg_chk(8'h04, 8'h03);
      reg_chk(8'h05, 8'h73);
      chk(shift_cfg, 3'b101);
      reg_wr(8'h06, 8'hff);
      reg_chk(8'h06, 8'h00);
      for (int i = 0; i < 48; i++)
      begin
         @(posedge sys_clk);
         {set_reset_val, set_reset_en, compare_colour, colour_ignore_n, bit_mask, ext_enable}
            <= 25'($urandom);
         rf = ($urandom & 32'he7) | (((i / 8) % 4) << 3);
         rp = $urandom;
         gm = ($urandom & 32'he8) | (i % 8);
         chain = 1'($urandom);
         gm[4] = ~chain;
         reg_wr(8'h03, 8'(rf));
         reg_wr(8'h04, 8'(rp));
         reg_wr(8'h05, 8'(gm));
         rf &= 32'h1f;
         rp &= 3;
         gm &= ext_enable ? 32'h7f : 32'h7b;
         reg_chk(8'h03, 8'(rf));
         reg_chk(8'h04, 8'(rp));
         reg_chk(8'h05, 8'(gm));
         chk(shift_cfg, {gm[6], gm[5] & ~gm[6], gm[4]});
         pl = $urandom;
         pgrw_host_model_i.xfer(6'h02, 8'h00, pl);
         @(negedge sys_clk);
         chk({cpu_rvalid, cpu_rdata}, {1'b1, exp_rd(pl)});
         lat = pl;
         pgrw_host_model_i.xfer(6'h04, 8'h00, ~pl);
         @(negedge sys_clk);
         chk({cpu_rvalid, cpu_rdata}, {1'b1, lat[rp]});
         d = $urandom;
         pgrw_host_model_i.xfer(6'h01, d, ~pl);
         @(negedge sys_clk);
         chk({mem_we, mem_wr}, {1'b1, exp_wr(d)});
      end
      test_done;
   end
endmodule : pgrw_datapath_tb
bind pgrw_datapath pgrw_datapath_monitor pgrw_datapath_monitor_i (.sys_clk, .rst_n,
   .io_data_rd, .io_rdata, .io_rvalid, .latch_rb_rd, .mem_rd_req, .mem_wr_req, .cpu_rdata,
   .cpu_rvalid, .mem_wr, .mem_we, .shift_cfg);
